// ---- rtl/bct_defs.svh ----
// Purpose: Constants for the board continuity test decode and pin control.
// Assumes: Included by its bare name from every design file that needs it.
// Notes: Tested-pin vector layout is fixed by the group offsets below.
`ifndef BCT_DEFS_SVH
`define BCT_DEFS_SVH

// Test select code for XOR tree mode, bits 3 down to 0.
`define BCT_SEL_XOR 4'h0
// Test select code for tristate mode, bits 3 down to 0.
`define BCT_SEL_TRI 4'h5
// Level of the active-low decode enable that arms the decode.
`define BCT_DECODE_ARMED 1'b0

// Width of the tested-pin vector.
`define BCT_TREE_W 172
// Group offsets inside the tested-pin vector (least significant bit of each group).
`define BCT_OFS_PCI_AD 0
`define BCT_OFS_PCI_CBE 64
`define BCT_OFS_PCI_CTRL 72
`define BCT_OFS_SYS_MISC 88
`define BCT_OFS_MEDIA 99
`define BCT_OFS_EEPROM 123
`define BCT_OFS_FLASH_ADDR 127
`define BCT_OFS_FLASH_STROBE 146
`define BCT_OFS_FLASH_DATA 148
`define BCT_OFS_LED 156
`define BCT_OFS_SDP 164
`define BCT_OFS_ALTCLK 171

// Reset values of the registered pin controls.
`define BCT_RST_CE_OUT 1'b1
`define BCT_RST_OE 1'b0
`define BCT_RST_DATA 1'b0

`endif

// ---- rtl/bct_pkg.sv ----
// Purpose: Types shared by the board continuity test modules.
// Assumes: Nothing beyond a SystemVerilog tool.
// Notes: Mode codes are one-hot and written out.
package bct_pkg;

	typedef enum logic [2:0]
	{
		BCT_MODE_NORMAL = 3'b001,
		BCT_MODE_XOR = 3'b010,
		BCT_MODE_TRI = 3'b100
	} bct_mode_e;

endpackage

// ---- rtl/bct_tree_if.sv ----
// Purpose: Carries the tested-pin levels to the XOR chain and its result back.
// Assumes: One source and one tree per instance.
// Notes: Width follows the tested-pin vector.
`timescale 1ns/1ns
`default_nettype none
interface bct_tree_if
#(
	parameter int W = 172
);
	logic [W-1:0] taps;
	logic result;

	modport src
	(
		output taps,
		input result
	);

	modport tree
	(
		input taps,
		output result
	);
endinterface
`default_nettype wire

// ---- rtl/bct_xor_tree.sv ----
// Purpose: Cascaded two-input XOR chain over all tested pins.
// Assumes: Tap levels are the pad input levels, never the core's drive.
// Notes: A true chain rather than a balanced tree; depth is irrelevant in test.
`timescale 1ns/1ns
`default_nettype none
module bct_xor_tree
#(
	parameter int W = 172
)
(
	bct_tree_if.tree tif
);
	logic stage;

	// Each stage folds in one distinct pin, so any single stuck pin flips the end.
	always_comb
	begin
		stage = tif.taps[0];
		for (int i = 1; i < W; i++)
		begin
			stage = stage ^ tif.taps[i]; // see RQ2
		end
		tif.result = stage;
	end
endmodule
`default_nettype wire

// ---- rtl/bct_test_modes.sv ----
// Purpose: Pin-level test decode, XOR continuity tree and forced tristate.
// Assumes: All inputs are synchronous to CLK; pad input levels arrive on TESTED_PIN_IN.
// Notes: Controls are registered, so a mode change shows one clock later.
`timescale 1ns/1ns
`default_nettype none
`include "bct_defs.svh"
// Functional notes
// RQ1: Decode low with select 0000 enters XOR.
// RQ2: Output is a cascaded two-input XOR chain.
// RQ3: Flash chip-enable driver enabled, carries tree result.
// RQ4: Tested pin drivers float in XOR mode.
// RQ5: Tested pins act only as tree inputs.
// RQ6: Tree covers bus, media, EEPROM, flash, LED pins.
// RQ7: Scan, decode, analog, regulator pins stay outside.
// RQ8: Fixture toggles each pin and watches output.
// RQ9: Decode low with select 0101 enters tristate.
// RQ10: Tristate floats all digital drivers except scan out.
// RQ11: Analog and regulator outputs unaffected by tristate.
// RQ12: Scan HIGHZ instruction also forces tristate.
// RQ13: Otherwise pins keep their normal function.
module bct_test_modes
#(
	parameter int TREE_W = `BCT_TREE_W
)
(
	// Clock and reset.
	input wire logic CLK,
	input wire logic RST,
	// Test decode pins, sampled as inputs.
	input wire logic TEST_DECODE_ENABLE_LOW,
	input wire logic TEST_SELECT_BIT3,
	input wire logic TEST_SELECT_BIT2,
	input wire logic TEST_SELECT_BIT1,
	input wire logic TEST_SELECT_BIT0,
	// Boundary-scan controller status and serial data output.
	input wire logic SCAN_HIGHZ_ACTIVE,
	input wire logic CORE_SCAN_DATA_OUT,
	input wire logic CORE_SCAN_DATA_OE,
	output logic SCAN_DATA_OUT,
	output logic SCAN_DATA_OE,
	// Tested pins: pad levels in, core drive requests in, pad enables out.
	input wire logic [TREE_W-1:0] TESTED_PIN_IN,
	input wire logic [TREE_W-1:0] CORE_TESTED_OE,
	output logic [TREE_W-1:0] TESTED_OE,
	// Flash chip-enable pin, doubling as tree output.
	input wire logic CORE_FLASH_CE_LOW,
	input wire logic CORE_FLASH_CE_OE,
	output logic FLASH_CHIP_ENABLE_LOW_OUT,
	output logic FLASH_CHIP_ENABLE_LOW_OE,
	// Other digital outputs outside the tree.
	input wire logic CORE_ALERT_OE,
	input wire logic CORE_CLOCK_VIEW_OE,
	output logic ALERT_OR_POWER_GOOD_OE,
	output logic CLOCK_VIEW_OE,
	// Current mode, for observation.
	output bct_pkg::bct_mode_e TEST_MODE
);
	import bct_pkg::*;

	bct_mode_e mode_reg;
	bct_mode_e mode_next;
	logic ce_out_reg;
	logic ce_out_next;
	logic ce_oe_reg;
	logic ce_oe_next;
	logic [TREE_W-1:0] tested_oe_reg;
	logic [TREE_W-1:0] tested_oe_next;
	logic alert_oe_reg;
	logic alert_oe_next;
	logic clk_view_oe_reg;
	logic clk_view_oe_next;
	logic scan_out_reg;
	logic scan_out_next;
	logic scan_oe_reg;
	logic scan_oe_next;

	bct_tree_if #(.W(TREE_W)) tree_bus ();

	// Pad levels only, so a pin the core would drive still reads as the fixture sets it.
	assign tree_bus.taps = TESTED_PIN_IN; // see RQ5 see RQ6

	bct_xor_tree #(.W(TREE_W)) u_tree
	(
		.tif(tree_bus)
	);

	// Scan HIGHZ outranks the pin decode, since the scan chain may run on any strap.
	function automatic bct_mode_e decode_mode(input logic en_low, input logic [3:0] sel,
		input logic highz);
		bct_mode_e m;
		m = BCT_MODE_NORMAL;
		if (highz)
		begin
			m = BCT_MODE_TRI; // see RQ12
		end
		else if (en_low == `BCT_DECODE_ARMED && sel == `BCT_SEL_TRI)
		begin
			m = BCT_MODE_TRI; // see RQ9
		end
		else if (en_low == `BCT_DECODE_ARMED && sel == `BCT_SEL_XOR)
		begin
			m = BCT_MODE_XOR; // see RQ1
		end
		return m;
	endfunction

	logic [3:0] sel_bits;
	assign sel_bits = {TEST_SELECT_BIT3, TEST_SELECT_BIT2, TEST_SELECT_BIT1, TEST_SELECT_BIT0};

	always_comb
	begin
		mode_next = decode_mode(TEST_DECODE_ENABLE_LOW, sel_bits, SCAN_HIGHZ_ACTIVE);
		scan_out_next = CORE_SCAN_DATA_OUT;
		scan_oe_next = CORE_SCAN_DATA_OE; // see RQ10
		case (mode_next)
			BCT_MODE_XOR:
			begin
				tested_oe_next = '0; // see RQ4 see RQ5
				ce_out_next = tree_bus.result; // see RQ3
				ce_oe_next = 1'b1; // see RQ3
				alert_oe_next = CORE_ALERT_OE; // see RQ7
				clk_view_oe_next = 1'b0;
			end
			BCT_MODE_TRI:
			begin
				tested_oe_next = '0; // see RQ10
				ce_out_next = CORE_FLASH_CE_LOW;
				ce_oe_next = 1'b0; // see RQ10
				alert_oe_next = 1'b0; // see RQ10
				clk_view_oe_next = 1'b0; // see RQ10
			end
			BCT_MODE_NORMAL:
			begin
				tested_oe_next = CORE_TESTED_OE; // see RQ13
				ce_out_next = CORE_FLASH_CE_LOW; // see RQ13
				ce_oe_next = CORE_FLASH_CE_OE;
				alert_oe_next = CORE_ALERT_OE;
				clk_view_oe_next = CORE_CLOCK_VIEW_OE;
			end
			default:
			begin
				tested_oe_next = '0;
				ce_out_next = `BCT_RST_CE_OUT;
				ce_oe_next = `BCT_RST_OE;
				alert_oe_next = `BCT_RST_OE;
				clk_view_oe_next = `BCT_RST_OE;
			end
		endcase
	end

	// Analog media pins and regulator controls never pass through here, so no mode
	// can disturb them; see RQ11.
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			mode_reg <= BCT_MODE_NORMAL;
			ce_out_reg <= `BCT_RST_CE_OUT;
			ce_oe_reg <= `BCT_RST_OE;
			tested_oe_reg <= '0;
			alert_oe_reg <= `BCT_RST_OE;
			clk_view_oe_reg <= `BCT_RST_OE;
			scan_out_reg <= `BCT_RST_DATA;
			scan_oe_reg <= `BCT_RST_OE;
		end
		else
		begin
			mode_reg <= mode_next;
			ce_out_reg <= ce_out_next;
			ce_oe_reg <= ce_oe_next;
			tested_oe_reg <= tested_oe_next;
			alert_oe_reg <= alert_oe_next;
			clk_view_oe_reg <= clk_view_oe_next;
			scan_out_reg <= scan_out_next;
			scan_oe_reg <= scan_oe_next;
		end
	end

	assign TEST_MODE = mode_reg;
	assign TESTED_OE = tested_oe_reg;
	assign FLASH_CHIP_ENABLE_LOW_OUT = ce_out_reg;
	assign FLASH_CHIP_ENABLE_LOW_OE = ce_oe_reg;
	assign ALERT_OR_POWER_GOOD_OE = alert_oe_reg;
	assign CLOCK_VIEW_OE = clk_view_oe_reg;
	assign SCAN_DATA_OUT = scan_out_reg;
	assign SCAN_DATA_OE = scan_oe_reg;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	// Antecedents that look a cycle ahead also test RST, because the release edge
	// starts attempts whose answer is still the reset value.
	AST_XOR_ENTRY: assert property ( // see RQ1
		(!RST && !TEST_DECODE_ENABLE_LOW && sel_bits == 4'h0 && !SCAN_HIGHZ_ACTIVE)
		|=> TEST_MODE == BCT_MODE_XOR)
		else $error("XOR code did not select XOR mode");

	AST_TREE_PARITY: assert property ( // see RQ2
		(TEST_MODE == BCT_MODE_XOR) |-> FLASH_CHIP_ENABLE_LOW_OUT == ^$past(TESTED_PIN_IN))
		else $error("Tree output is not the parity of the tested pins");

	AST_CE_DRIVEN: assert property ( // see RQ3
		(TEST_MODE == BCT_MODE_XOR) |-> FLASH_CHIP_ENABLE_LOW_OE)
		else $error("Tree output driver not enabled in XOR mode");

	AST_TESTED_FLOAT: assert property ( // see RQ4
		(TEST_MODE != BCT_MODE_NORMAL) |-> TESTED_OE == '0)
		else $error("Tested pin driver active in a test mode");

	AST_TRI_ENTRY: assert property ( // see RQ9
		(!RST && !TEST_DECODE_ENABLE_LOW && sel_bits == 4'h5)
		|=> TEST_MODE == BCT_MODE_TRI ##1 1'b1)
		else $error("Tristate code did not select tristate mode");

	AST_TRI_FLOAT: assert property ( // see RQ10
		(TEST_MODE == BCT_MODE_TRI)
		|-> !FLASH_CHIP_ENABLE_LOW_OE && !ALERT_OR_POWER_GOOD_OE && !CLOCK_VIEW_OE
		&& SCAN_DATA_OE == $past(CORE_SCAN_DATA_OE))
		else $error("Digital driver active in tristate or scan output lost");

	AST_HIGHZ_ROUTE: assert property ( // see RQ12
		(!RST && SCAN_HIGHZ_ACTIVE) ##1 SCAN_HIGHZ_ACTIVE
		|-> TEST_MODE == BCT_MODE_TRI && TESTED_OE == '0)
		else $error("Scan HIGHZ did not force tristate");

	AST_NORMAL_PASS: assert property ( // see RQ13
		(!RST && decode_mode(TEST_DECODE_ENABLE_LOW, sel_bits, SCAN_HIGHZ_ACTIVE)
		== BCT_MODE_NORMAL)
		|=> TESTED_OE == $past(CORE_TESTED_OE)
		&& FLASH_CHIP_ENABLE_LOW_OE == $past(CORE_FLASH_CE_OE)
		&& FLASH_CHIP_ENABLE_LOW_OUT == $past(CORE_FLASH_CE_LOW))
		else $error("Normal mode does not pass core pin controls");

	AST_ALERT_OUTSIDE: assert property ( // see RQ7
		(TEST_MODE == BCT_MODE_XOR) |-> ALERT_OR_POWER_GOOD_OE == $past(CORE_ALERT_OE))
		else $error("Alert pin disturbed by XOR mode");
endmodule
`default_nettype wire

// ---- verif/bct_board_fixture.sv ----
// Purpose: Board fixture and boundary-scan controller at the device pins.
// Assumes: The bench chooses pad levels and the loaded scan instruction.
// Notes: The fixture owns every tested pad, so levels pass straight through.
`timescale 1ns/1ns
`default_nettype none
module bct_board_fixture
(
	// Requests from the bench.
	input wire logic [171:0] pin_req,
	input wire logic hz_req,
	// Pad levels and scan status.
	output logic [171:0] pin_level,
	output logic highz_loaded
);
	assign pin_level = pin_req;
	assign highz_loaded = hz_req;
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// Purpose: Self-checking bench for the board continuity test modes.
// Assumes: Every output follows the inputs of the previous clock edge.
// Notes: Every decode code, a walk of each tested pin, random steps, reset.
`timescale 1ns/1ns
`default_nettype none
`include "bct_defs.svh"
module tb;
	import bct_pkg::*;
	localparam int W = `BCT_TREE_W;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic en_low = 1'b1;
	logic [3:0] sel = 4'h0;
	logic hz_req = 1'b0;
	logic [W-1:0] pin_req = '0;
	logic [W-1:0] core_oe = '0;
	logic [5:0] core = 6'h0;
	logic [W-1:0] pins;
	logic hz;
	logic scan_out, scan_oe, ce_out, ce_oe, alert_oe, view_oe;
	logic [W-1:0] t_oe;
	bct_mode_e mode;
	int mismatches = 0;
	int check_count = 0;
	always #5 clk = ~clk;
	bct_board_fixture u_bct_board_fixture (.pin_req(pin_req), .hz_req(hz_req),
		.pin_level(pins), .highz_loaded(hz));
	bct_test_modes u_bct_test_modes (.CLK(clk), .RST(rst), .TEST_DECODE_ENABLE_LOW(en_low),
		.TEST_SELECT_BIT3(sel[3]), .TEST_SELECT_BIT2(sel[2]), .TEST_SELECT_BIT1(sel[1]),
		.TEST_SELECT_BIT0(sel[0]), .SCAN_HIGHZ_ACTIVE(hz), .CORE_SCAN_DATA_OUT(core[5]),
		.CORE_SCAN_DATA_OE(core[4]), .SCAN_DATA_OUT(scan_out), .SCAN_DATA_OE(scan_oe),
		.TESTED_PIN_IN(pins), .CORE_TESTED_OE(core_oe), .TESTED_OE(t_oe),
		.CORE_FLASH_CE_LOW(core[3]), .CORE_FLASH_CE_OE(core[2]),
		.FLASH_CHIP_ENABLE_LOW_OUT(ce_out), .FLASH_CHIP_ENABLE_LOW_OE(ce_oe),
		.CORE_ALERT_OE(core[1]), .CORE_CLOCK_VIEW_OE(core[0]),
		.ALERT_OR_POWER_GOOD_OE(alert_oe), .CLOCK_VIEW_OE(view_oe), .TEST_MODE(mode));
	function automatic bct_mode_e exp_mode(logic e, logic [3:0] s, logic h);
		if (h)
			return BCT_MODE_TRI;
		if (!e && s == 4'h0)
			return BCT_MODE_XOR;
		if (!e && s == 4'h5)
			return BCT_MODE_TRI;
		return BCT_MODE_NORMAL;
	endfunction
	function automatic logic [W-1:0] rnd_w();
		return W'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
	endfunction
	task automatic final_report();
		if (mismatches == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(string what, logic [W-1:0] seen, logic [W-1:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Core requests are randomised on every step, so a forced pin cannot hide behind them.
	task automatic step(logic e, logic [3:0] s, logic h, logic [W-1:0] p);
		bct_mode_e m;
		m = exp_mode(e, s, h);
		@(posedge clk);
		en_low <= e;
		sel <= s;
		hz_req <= h;
		pin_req <= p;
		core_oe <= rnd_w();
		core <= 6'($urandom);
		@(posedge clk);
		#1;
		chk("mode", W'(mode), W'(m));
		chk("tested_oe", t_oe, m == BCT_MODE_NORMAL ? core_oe : '0);
		chk("ce_out", W'(ce_out), W'(m == BCT_MODE_XOR ? ^p : core[3]));
		chk("ce_oe", W'(ce_oe), W'(m == BCT_MODE_XOR ? 1'b1 : m == BCT_MODE_TRI ? 1'b0
			: core[2]));
		chk("alert_oe", W'(alert_oe), W'(m == BCT_MODE_TRI ? 1'b0 : core[1]));
		chk("view_oe", W'(view_oe), W'(m == BCT_MODE_NORMAL ? core[0] : 1'b0));
		chk("scan", W'({scan_out, scan_oe}), W'(core[5:4]));
	endtask
	initial
	begin
		logic [31:0] r;
		void'($urandom(32'h7b5f880e));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 64; i++)
			step(i[4], i[3:0], i[5], rnd_w());
		for (int i = 0; i < W; i++)
		begin
			step(1'b0, 4'h0, 1'b0, W'(1) << i);
			step(1'b0, 4'h0, 1'b0, '0);
		end
		for (int i = 0; i < 300; i++)
		begin
			r = $urandom;
			step(r[0] & r[1], r[2] ? 4'h0 : (r[3] ? 4'h5 : r[7:4]), r[8] & r[9], rnd_w());
		end
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		#1;
		chk("reset_mode", W'(mode), W'(BCT_MODE_NORMAL));
		chk("reset_ce", W'(ce_out), W'(1'b1));
		chk("reset_oe", t_oe, '0);
		chk("reset_pin_oe", W'({ce_oe, alert_oe, view_oe, scan_oe}), W'(4'h0));
		chk("reset_scan", W'(scan_out), W'(1'b0));
		// Leave reset in mid-run and check that decoding resumes at once.
		@(posedge clk);
		rst <= 1'b0;
		step(1'b0, 4'h0, 1'b0, rnd_w());
		step(1'b0, 4'h5, 1'b1, rnd_w());
		final_report();
	end
endmodule
`default_nettype wire
